/* File: ebt_consts.svh */
// Register offsets, field positions, reset values and timing counts of the eight-bit timer
`ifndef EBT_CONSTS_SVH
`define EBT_CONSTS_SVH

// Register byte offsets
`define EBT_OFS_COUNT    8'h00
`define EBT_OFS_OPTION   8'h04
`define EBT_OFS_STATUS   8'h08
`define EBT_OFS_MASK     8'h0C

// Option register fields
`define EBT_OPT_CS_BIT   5
`define EBT_OPT_SE_BIT   4
`define EBT_OPT_PSA_BIT  3
`define EBT_OPT_PS_MSB   2
`define EBT_OPT_PS_LSB   0
`define EBT_OPT_WMASK    8'h3F

// Status and mask fields
`define EBT_OVF_BIT      0

// Reset values
`define EBT_RST_COUNT    8'h00
`define EBT_RST_OPTION   8'h08
`define EBT_RST_STATUS   8'h00
`define EBT_RST_MASK     8'h00

// Instruction cycles without increment after a count write
`define EBT_INHIBIT_CYC  2'h2

`endif

/* File: ebt_pkg.sv */
// Types shared by the eight-bit timer design
package ebt_pkg;

  typedef logic [7:0] ebt_byte_t;

  typedef enum logic {
    EBT_SRC_TIMER,
    EBT_SRC_COUNTER
  } ebt_src_t;

  // Prescaler terminal mask for a rate code: 1:2 up to 1:256
  function automatic ebt_byte_t ebt_ps_mask(input logic [2:0] rate);
    ebt_ps_mask = ebt_byte_t'((9'h002 << rate) - 9'h001);
  endfunction : ebt_ps_mask

endpackage : ebt_pkg

/* File: ebt_edge_sel.sv */
// Edge detector for the external count input with selectable polarity
`timescale 1ns/100ps
`default_nettype none

module ebt_edge_sel (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Pin and selection
  input  wire logic pin_in,
  input  wire logic fall_sel,
  // Qualifying transition
  output logic      edge_hit
);

  logic pin_prev_r;
  wire  rise_w;
  wire  fall_w;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_in;
    end
  end

  assign rise_w   = pin_in & ~pin_prev_r;
  assign fall_w   = ~pin_in & pin_prev_r;
  assign edge_hit = fall_sel ? fall_w : rise_w;

  AST_EDGE_POLARITY: assert property (@(posedge hclk) disable iff (!hresetn)
    edge_hit |-> (pin_in != pin_prev_r) && (pin_in == !fall_sel))
    else $error("edge hit on wrong transition");

endmodule : ebt_edge_sel

`default_nettype wire

/* File: ebt_prescaler.sv */
// Eight-bit prescaler with a three-bit rate code, private to the eight-bit timer
`timescale 1ns/100ps
`default_nettype none

module ebt_prescaler (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [2:0] rate,
  // Divided tick
  output logic            tick_out
);

  ebt_pkg::ebt_byte_t pre_r;
  ebt_pkg::ebt_byte_t pre_nxt;
  ebt_pkg::ebt_byte_t term_w;

  assign term_w   = ebt_pkg::ebt_ps_mask(rate);
  // A clear restarts the period, so no tick may leave in that cycle
  assign tick_out = tick_in && !clear && ((pre_r & term_w) == term_w);
  assign pre_nxt  = clear ? 8'h00 : (tick_in ? pre_r + 8'h01 : pre_r);

  // Own counter, never shared with the watchdog
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 8'h00;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  AST_PRESC_SOURCE: assert property (@(posedge hclk) disable iff (!hresetn)
    tick_out |-> tick_in && !clear ##1 ((pre_r & $past(term_w)) == 8'h00))
    else $error("prescaler did not restart its period after a tick");

endmodule : ebt_prescaler

`default_nettype wire

/* File: ebt_timer.sv */
// Eight-bit timer/counter with AHB-Lite register access and overflow interrupt
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ebt_consts.svh"

// Functional notes
// - Eight-bit count register, timer or event counter
// - Unprescaled timer advances every instruction cycle
// - Clock-source select zero gives timer mode
// - No increment for two cycles after write
// - Counter mode advances per qualifying pin transition
// - Clock-source select one gives counter mode
// - Edge select picks rising or falling transitions
// - Own eight-bit prescaler with three-bit rate code, not shared with watchdog
// - Output offered as gate source for second timer
module ebt_timer (
  // AHB-Lite clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite request
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  // AHB-Lite answer
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // External count pin
  input  wire logic        external_count_input,
  // Interrupt and gate for the second timer
  output logic             irq,
  output logic             second_timer_gate
);

  // Register state
  ebt_pkg::ebt_byte_t count_register_r;
  ebt_pkg::ebt_byte_t count_register_nxt;
  ebt_pkg::ebt_byte_t option_r;
  ebt_pkg::ebt_byte_t option_nxt;
  ebt_pkg::ebt_byte_t status_r;
  ebt_pkg::ebt_byte_t status_nxt;
  ebt_pkg::ebt_byte_t mask_r;
  ebt_pkg::ebt_byte_t mask_nxt;
  logic [1:0]         inhibit_r;
  logic [1:0]         inhibit_nxt;

  // Bus pipeline state
  logic               wr_pend_r;
  logic [7:0]         wr_addr_r;
  logic [31:0]        hrdata_r;
  logic [31:0]        hrdata_nxt;
  logic               hreadyout_r;
  logic               irq_r;
  logic               irq_nxt;
  logic               gate_r;
  logic               hresp_r;

  // Address phase decode
  wire                addr_take;
  wire                rd_take;
  wire                wr_take;
  wire [7:0]          ofs_w;
  wire                hit_count;
  wire                hit_option;
  wire                hit_status;
  wire                hit_mask;
  wire                hit_any;

  assign addr_take  = hsel && htrans[1] && hready;
  assign rd_take    = addr_take && !hwrite;
  assign wr_take    = addr_take && hwrite;
  assign ofs_w      = haddr[7:0];
  assign hit_count  = (ofs_w == `EBT_OFS_COUNT);
  assign hit_option = (ofs_w == `EBT_OFS_OPTION);
  assign hit_status = (ofs_w == `EBT_OFS_STATUS);
  assign hit_mask   = (ofs_w == `EBT_OFS_MASK);
  assign hit_any    = (haddr[31:8] == 24'h000000) && (hit_count || hit_option || hit_status || hit_mask);

  // Data phase write strobes
  wire                count_wr;
  wire                option_wr;
  wire                mask_wr;

  assign count_wr  = wr_pend_r && (wr_addr_r == `EBT_OFS_COUNT);
  assign option_wr = wr_pend_r && (wr_addr_r == `EBT_OFS_OPTION);
  assign mask_wr   = wr_pend_r && (wr_addr_r == `EBT_OFS_MASK);

  // Option fields
  ebt_pkg::ebt_src_t  src_w;
  wire                fall_sel_w;
  wire                ps_bypass_w;
  wire [2:0]          ps_rate_w;

  assign src_w       = option_r[`EBT_OPT_CS_BIT] ? ebt_pkg::EBT_SRC_COUNTER : ebt_pkg::EBT_SRC_TIMER;
  assign fall_sel_w  = option_r[`EBT_OPT_SE_BIT];
  assign ps_bypass_w = option_r[`EBT_OPT_PSA_BIT];
  assign ps_rate_w   = option_r[`EBT_OPT_PS_MSB:`EBT_OPT_PS_LSB];

  // Count source: every hclk is one instruction cycle
  wire                edge_hit_w;
  wire                raw_tick_w;
  wire                pre_tick_w;
  wire                src_tick_w;
  wire                inc_en;
  wire                ovf_w;

  ebt_edge_sel u_edge (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pin_in   (external_count_input),
    .fall_sel (fall_sel_w),
    .edge_hit (edge_hit_w)
  );

  assign raw_tick_w = (src_w == ebt_pkg::EBT_SRC_COUNTER) ? edge_hit_w : 1'b1;

  // A count write restarts the prescaler so the first period is whole
  ebt_prescaler u_presc (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clear    (count_wr),
    .tick_in  (raw_tick_w && !ps_bypass_w),
    .rate     (ps_rate_w),
    .tick_out (pre_tick_w)
  );

  assign src_tick_w = ps_bypass_w ? raw_tick_w : pre_tick_w;
  assign inc_en     = src_tick_w && (inhibit_r == 2'h0) && !count_wr;
  assign ovf_w      = inc_en && (count_register_r == 8'hFF);

  // Next-state logic
  assign count_register_nxt = count_wr ? hwdata[7:0] :
                              (inc_en ? count_register_r + 8'h01 : count_register_r);
  assign inhibit_nxt        = count_wr ? `EBT_INHIBIT_CYC :
                              ((inhibit_r != 2'h0) ? inhibit_r - 2'h1 : 2'h0);
  assign option_nxt         = option_wr ? (hwdata[7:0] & `EBT_OPT_WMASK) : option_r;
  assign mask_nxt           = mask_wr ? {7'h00, hwdata[`EBT_OVF_BIT]} : mask_r;

  // Read clears the flag, but an overflow in the same cycle wins
  wire                status_clr;
  assign status_clr = rd_take && hit_status && hit_any;
  assign status_nxt = {7'h00, ovf_w || (status_r[`EBT_OVF_BIT] && !status_clr)};
  assign irq_nxt    = |(status_nxt & mask_nxt);

  // Read data is captured at the address phase and shown in the data phase
  wire [31:0]         rd_mux;
  assign rd_mux = !hit_any   ? 32'h00000000 :
                  hit_count  ? {24'h000000, count_register_r} :
                  hit_option ? {24'h000000, option_r} :
                  hit_status ? {24'h000000, status_r} :
                               {24'h000000, mask_r};
  assign hrdata_nxt = rd_take ? rd_mux : 32'h00000000;

  // Count register: a bus load wins over an increment in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_register_r <= `EBT_RST_COUNT;
    end else begin
      count_register_r <= count_register_nxt;
    end
  end

  // Inhibit counter: loaded by a count write, runs down to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inhibit_r <= 2'h0;
    end else begin
      inhibit_r <= inhibit_nxt;
    end
  end

  // Reset leaves timer mode with the prescaler bypassed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      option_r <= `EBT_RST_OPTION;
    end else begin
      option_r <= option_nxt;
    end
  end

  // Sticky overflow flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= `EBT_RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= `EBT_RST_MASK;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_take && hit_any;
      wr_addr_r <= ofs_w;
    end
  end

  // Zero-wait slave: ready and OKAY are held by flops for the output rule
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r    <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hrdata_r    <= hrdata_nxt;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  // The gate pulse marks each rollover for the second timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r  <= 1'b0;
      gate_r <= 1'b0;
    end else begin
      irq_r  <= irq_nxt;
      gate_r <= ovf_w;
    end
  end

  assign hrdata            = hrdata_r;
  assign hreadyout         = hreadyout_r;
  assign hresp             = hresp_r;
  assign irq               = irq_r;
  assign second_timer_gate = gate_r;

  // hsize is accepted but only whole words are meaningful here
  wire                unused_w;
  assign unused_w = ^hsize;

  AST_WRAP_TO_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    (count_register_r == 8'hFF) && inc_en |=> (count_register_r == 8'h00))
    else $error("count did not wrap to zero");

  AST_TIMER_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    (!option_r[`EBT_OPT_CS_BIT] && option_r[`EBT_OPT_PSA_BIT] && (inhibit_r == 2'h0) && !count_wr)
    |=> (count_register_r == $past(count_register_r) + 8'h01))
    else $error("timer mode did not advance by one");

  AST_TIMER_SOURCE: assert property (@(posedge hclk) disable iff (!hresetn)
    !option_r[`EBT_OPT_CS_BIT] && option_r[`EBT_OPT_PSA_BIT] |-> (raw_tick_w && src_tick_w))
    else $error("timer mode not ticking every cycle");

  AST_INHIBIT_TWO: assert property (@(posedge hclk) disable iff (!hresetn)
    count_wr ##1 !count_wr |-> !inc_en ##1 (!inc_en || count_wr))
    else $error("increment during the two cycles after a write");

  AST_COUNTER_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    option_r[`EBT_OPT_CS_BIT] && !edge_hit_w && !count_wr |=> $stable(count_register_r))
    else $error("counter mode advanced without a pin edge");

  AST_COUNTER_SOURCE: assert property (@(posedge hclk) disable iff (!hresetn)
    option_r[`EBT_OPT_CS_BIT] |-> (raw_tick_w == edge_hit_w))
    else $error("counter mode source is not the pin edge");

  AST_GATE_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
    second_timer_gate |-> $past(count_register_r == 8'hFF) && (count_register_r == 8'h00))
    else $error("gate pulse without a rollover");

  AST_OVF_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_w |=> status_r[`EBT_OVF_BIT] ##0 (irq == mask_r[`EBT_OVF_BIT]))
    else $error("overflow flag or interrupt not raised");

  AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
    !status_r[`EBT_OVF_BIT] || !mask_r[`EBT_OVF_BIT] |-> !irq)
    else $error("interrupt high with no unmasked flag");

  // Load and inhibit
  AST_LOAD_VALUE: assert property (@(posedge hclk) disable iff (!hresetn)
    count_wr |=> (count_register_r == $past(hwdata[7:0])))
    else $error("count write did not load the bus value");

  AST_INHIBIT_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
    count_wr |=> (inhibit_r == `EBT_INHIBIT_CYC))
    else $error("inhibit count not loaded by a count write");

  AST_INHIBIT_NO_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    (inhibit_r != 2'h0) && !count_wr |=> $stable(count_register_r))
    else $error("count advanced while inhibited");

  // Pin edge selection
  AST_COUNTER_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    option_r[`EBT_OPT_CS_BIT] && option_r[`EBT_OPT_PSA_BIT] && edge_hit_w && (inhibit_r == 2'h0) && !count_wr
    |=> (count_register_r == $past(count_register_r) + 8'h01))
    else $error("counter mode missed a pin edge");

  AST_RISE_SELECT: assert property (@(posedge hclk) disable iff (!hresetn)
    option_r[`EBT_OPT_CS_BIT] && !option_r[`EBT_OPT_SE_BIT] && !external_count_input && !count_wr
    |=> $stable(count_register_r))
    else $error("rising select advanced on a low pin");

  AST_FALL_SELECT: assert property (@(posedge hclk) disable iff (!hresetn)
    option_r[`EBT_OPT_CS_BIT] && option_r[`EBT_OPT_SE_BIT] && external_count_input && !count_wr
    |=> $stable(count_register_r))
    else $error("falling select advanced on a high pin");

  // Prescaler path
  AST_PRESC_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !option_r[`EBT_OPT_PSA_BIT] && !pre_tick_w && !count_wr |=> $stable(count_register_r))
    else $error("prescaled count advanced without a prescaler tick");

  AST_PRESC_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    !option_r[`EBT_OPT_PSA_BIT] && pre_tick_w && (inhibit_r == 2'h0) && !count_wr
    |=> (count_register_r == $past(count_register_r) + 8'h01))
    else $error("prescaler tick did not advance the count");

  // Gate, flag and interrupt
  AST_GATE_FOLLOWS: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_w |=> second_timer_gate)
    else $error("rollover without a gate pulse");

  AST_GATE_SINGLE: assert property (@(posedge hclk) disable iff (!hresetn)
    second_timer_gate |=> !second_timer_gate)
    else $error("gate pulse longer than one cycle");

  AST_FLAG_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
    status_r[`EBT_OVF_BIT] && !status_clr |=> status_r[`EBT_OVF_BIT])
    else $error("overflow flag lost without a status read");

  AST_FLAG_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    status_clr && !ovf_w |=> !status_r[`EBT_OVF_BIT])
    else $error("status read did not clear the overflow flag");

  AST_FLAG_CAUSE: assert property (@(posedge hclk) disable iff (!hresetn)
    !status_r[`EBT_OVF_BIT] && !ovf_w |=> !status_r[`EBT_OVF_BIT])
    else $error("overflow flag set without a rollover");

  AST_IRQ_RAISE: assert property (@(posedge hclk) disable iff (!hresetn)
    status_r[`EBT_OVF_BIT] && mask_r[`EBT_OVF_BIT] |-> irq)
    else $error("unmasked flag without an interrupt");

endmodule : ebt_timer

`default_nettype wire

/* File: ebt_pin_model.sv */
// Signal source driving the external count pin with whole pulses
`timescale 1ns/100ps
`default_nettype none

module ebt_pin_model (
  // Clock
  input  wire logic        hclk,
  // Command
  input  wire logic        go,
  input  wire logic [15:0] n_pulses,
  input  wire logic [3:0]  half,
  // Pin and state
  output var logic         pin,
  output var logic         busy
);
  logic [15:0] left_r;
  logic [3:0]  cnt_r;

  // Pin rests low between bursts so no stray edge reaches the block
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    left_r = 16'h0000;
    cnt_r = 4'h0;
  end

  always @(posedge hclk) begin
    if (go && !busy && n_pulses != 16'h0000) begin
      busy <= 1'b1;
      left_r <= n_pulses;
      cnt_r <= half;
    end else if (busy) begin
      if (cnt_r > 4'h1) begin
        cnt_r <= cnt_r - 4'h1;
      end else begin
        cnt_r <= half;
        pin <= ~pin;
        if (pin) begin
          left_r <= left_r - 16'h0001;
          busy <= (left_r != 16'h0001);
        end
      end
    end
  end
endmodule : ebt_pin_model

`default_nettype wire

/* File: eight_bit_timer_counter_tb.sv */
// Self-checking bench of the eight-bit timer with a scoreboard of read results
`timescale 1ns/100ps
`default_nettype none
`include "ebt_consts.svh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; $display("wrong value %s expected %h seen %h", nm, e, s); end end

module eight_bit_timer_counter_tb;
  logic        hclk, hresetn, hsel, hwrite, hready, go, busy, pin;
  logic [31:0] haddr, hwdata, hrdata, rd_val;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] n_pulses;
  logic [3:0]  half;
  logic        hresp, irq, second_timer_gate;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'hfab7b5df;
  logic [7:0]  v;
  logic [31:0] exp_v;
  int          n_fail, checked, n_gate, n;
  event        done_ev;

  ebt_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .external_count_input(pin), .irq(irq),
    .second_timer_gate(second_timer_gate));
  ebt_pin_model i_pin (.hclk(hclk), .go(go), .n_pulses(n_pulses), .half(half), .pin(pin), .busy(busy));

  always #10 hclk = ~hclk;
  always @(posedge hclk) if (second_timer_gate === 1'b1) n_gate++;

  task automatic stop_test;
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // Single transfer; waits on hready rather than assuming a latency
  task automatic bus_go(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_val = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : bus_go

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus_go(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus_go(a, 1'b0, $random(seed));
    -> done_ev;
  endtask : rd

  task automatic pulses(input int cnt);
    n_pulses <= cnt[15:0];
    half <= 4'h1 + 4'($random(seed) & 3);
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (2) @(posedge hclk);
    while (busy) @(posedge hclk);
    repeat (4) @(posedge hclk);
  endtask : pulses

  always begin
    @(done_ev);
    exp_v = exp_q.pop_front();
    `CHK("hrdata", exp_v, rd_val)
  end

  initial begin
    repeat (60000) @(posedge hclk);
    n_fail++;
    stop_test();
  end

  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; go = 1'b0; n_pulses = 16'h0; half = 4'h1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`EBT_OFS_OPTION, 32'h08);
    rd(`EBT_OFS_STATUS, 32'h00);
    rd(`EBT_OFS_MASK, 32'h00);
    wr(`EBT_OFS_OPTION, 32'hFFFFFFE8);
    rd(`EBT_OFS_OPTION, 32'h28);
    wr(32'h10, 32'hFF);
    rd(32'h10, 32'h00);
    // Timer mode: load, two idle cycles, then one step per cycle
    wr(`EBT_OFS_OPTION, 32'h08);
    v = 8'($random(seed));
    wr(`EBT_OFS_COUNT, {24'h0, v});
    rd(`EBT_OFS_COUNT, {24'h0, v});
    rd(`EBT_OFS_COUNT, {24'h0, v});
    rd(`EBT_OFS_COUNT, {24'h0, v + 8'h02});
    rd(`EBT_OFS_COUNT, {24'h0, v + 8'h04});
    // Pin counting on each edge polarity
    for (int m = 0; m < 2; m++) begin
      wr(`EBT_OFS_OPTION, m ? 32'h38 : 32'h28);
      wr(`EBT_OFS_COUNT, 32'h0);
      n = 1 + ($random(seed) & 31);
      pulses(n);
      rd(`EBT_OFS_COUNT, 32'(n));
    end
    // One short of two prescaler periods leaves exactly one step
    for (int r = 0; r < 8; r++) begin
      wr(`EBT_OFS_OPTION, 32'h20 | r);
      wr(`EBT_OFS_COUNT, 32'h0);
      pulses((4 << r) - 1);
      rd(`EBT_OFS_COUNT, 32'h01);
    end
    wr(`EBT_OFS_OPTION, 32'h28);
    bus_go(`EBT_OFS_STATUS, 1'b0, 32'h0);
    for (int k = 1; k >= 0; k--) begin
      wr(`EBT_OFS_MASK, 32'(k));
      wr(`EBT_OFS_COUNT, 32'hFF);
      n_gate = 0;
      pulses(1);
      `CHK("irq", 1'(k), irq)
      `CHK("gate", 1, n_gate)
      rd(`EBT_OFS_COUNT, 32'h00);
      rd(`EBT_OFS_STATUS, 32'h01);
      @(negedge hclk);
      `CHK("irq", 1'b0, irq)
      rd(`EBT_OFS_STATUS, 32'h00);
    end
    repeat (2) @(posedge hclk);
    stop_test();
  end
endmodule : eight_bit_timer_counter_tb

`default_nettype wire
